/* logic/fec_pll_ctrl.sv */
// FEC PLL control: reference mux, ratio dividers, post divider, lock loss detector, APB registers
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "fec_pll_map.svh"
module fec_pll_ctrl #(
  parameter logic [11:0] MISS_LIMIT = `FPL_MISS_LIMIT
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Reference and oscillator pins
  input wire logic I_REF_IN_A,
  input wire logic I_REF_IN_B,
  input wire logic I_OSC_IN,
  // Loop control to the analog core
  output logic O_PUMP_UP,
  output logic O_PUMP_DN,
  output logic O_BW_NARROW,
  // Output clock pins
  output logic O_CLOCK_OUT_POS,
  output logic O_CLOCK_OUT_NEG,
  output logic O_CLOCK_OUT_OE,
  // Status and interrupt
  output logic O_LOCK_LOSS_FLAG,
  output logic O_IRQ
);
  // Pin synchronisers and rising-edge detect
  logic [2:0] pin_in;
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;
  logic [2:0] rise;

  assign pin_in = {I_OSC_IN, I_REF_IN_B, I_REF_IN_A};

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      assign rise[g] = sync_reg[g] & ~prev_reg[g];
    end
  endgenerate

  // Control decode
  logic [8:0] ctrl_reg;
  logic ref_choice;
  logic [1:0] ratio_sel;
  logic [1:0] fin_sel;
  logic [2:0] out_sel;
  logic [6:0] mfec_val;
  logic [6:0] rfec_val;
  logic [5:0] mfin_val;
  logic [5:0] p_val;
  logic [12:0] fb_div;
  logic out_tri;
  logic ref_edge;

  assign ref_choice = ctrl_reg[`FPL_CTRL_REF_BIT];
  assign ratio_sel = ctrl_reg[`FPL_CTRL_RATIO_LSB +: 2];
  assign fin_sel = {ctrl_reg[`FPL_CTRL_FIN_HI_BIT], ctrl_reg[`FPL_CTRL_FIN_LO_BIT]};
  assign out_sel = ctrl_reg[`FPL_CTRL_PSEL_LSB +: 3];
  assign ref_edge = ref_choice ? rise[1] : rise[0];
  assign mfec_val = ratio_sel[1] ? `FPL_MFEC_1X : `FPL_MFEC_0X;
  assign rfec_val = (ratio_sel == 2'h0) ? `FPL_RFEC_00 :
                    (ratio_sel == 2'h1) ? `FPL_RFEC_01 :
                    (ratio_sel == 2'h2) ? `FPL_RFEC_10 : `FPL_RFEC_11;
  assign mfin_val = (fin_sel == 2'h0) ? `FPL_MFIN_00 :
                    (fin_sel == 2'h1) ? `FPL_MFIN_01 :
                    (fin_sel == 2'h2) ? `FPL_MFIN_10 : `FPL_MFIN_11;
  // Feedback divides the oscillator by input divider times feedback ratio
  assign fb_div = 13'(mfin_val) * 13'(mfec_val);
  assign p_val = (out_sel == 3'h2) ? `FPL_P_1 :
                 (out_sel == 3'h3 || out_sel == 3'h5) ? `FPL_P_4 :
                 (out_sel == 3'h4 || out_sel == 3'h6) ? `FPL_P_8 : `FPL_P_32;
  assign out_tri = out_sel == `FPL_PSEL_TRI;

  // Reference, feedback and post dividers
  logic ref_tick;
  logic fb_tick;
  logic post_high;

  pulse_divider #(.W(7)) u_ref_div (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_edge(ref_edge),
    .i_div(rfec_val),
    .o_tick(ref_tick),
    .o_high()
  );

  pulse_divider #(.W(13)) u_fb_div (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_edge(rise[2]),
    .i_div(fb_div),
    .o_tick(fb_tick),
    .o_high()
  );

  pulse_divider #(.W(6)) u_post_div (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_edge(rise[2]),
    .i_div(p_val),
    .o_tick(),
    .o_high(post_high)
  );

  // Lock detector: measures edge distance per comparison cycle
  fec_pll_pkg::lock_state_type state_reg;
  fec_pll_pkg::lock_state_type state_next;
  logic [11:0] diff_reg;
  logic [11:0] diff_next;
  logic [11:0] meas;
  logic done;
  logic miss;
  logic lol_reg;
  logic lol_next;

  always_comb begin
    state_next = state_reg;
    diff_next = diff_reg;
    meas = diff_reg;
    done = 1'b0;
    miss = 1'b0;
    case (state_reg)
      fec_pll_pkg::LK_IDLE: begin
        if (ref_tick && fb_tick) begin
          done = 1'b1;
          meas = 12'h000;
        end else if (ref_tick) begin
          state_next = fec_pll_pkg::LK_WAIT_FB;
          diff_next = 12'h001;
        end else if (fb_tick) begin
          state_next = fec_pll_pkg::LK_WAIT_REF;
          diff_next = 12'h001;
        end
      end
      fec_pll_pkg::LK_WAIT_FB: begin
        if (fb_tick) begin
          done = 1'b1;
          state_next = fec_pll_pkg::LK_IDLE;
        end else if (ref_tick || diff_reg == MISS_LIMIT) begin
          miss = 1'b1;
          state_next = ref_tick ? fec_pll_pkg::LK_WAIT_FB : fec_pll_pkg::LK_IDLE;
          diff_next = 12'h001;
        end else begin
          diff_next = diff_reg + 12'h001;
        end
      end
      fec_pll_pkg::LK_WAIT_REF: begin
        if (ref_tick) begin
          done = 1'b1;
          state_next = fec_pll_pkg::LK_IDLE;
        end else if (fb_tick || diff_reg == MISS_LIMIT) begin
          miss = 1'b1;
          state_next = fb_tick ? fec_pll_pkg::LK_WAIT_REF : fec_pll_pkg::LK_IDLE;
          diff_next = 12'h001;
        end else begin
          diff_next = diff_reg + 12'h001;
        end
      end
      default: begin
        state_next = fec_pll_pkg::LK_IDLE;
        diff_next = 12'h000;
      end
    endcase
  end

  // Assert above the upper threshold, release below the lower, else hold
  assign lol_next = (miss || (done && meas >= 12'(`FPL_LOL_ASSERT_CYC))) ? 1'b1 :
                    (done && meas < 12'(`FPL_LOL_RELEASE_CYC)) ? 1'b0 : lol_reg;

  // APB decode
  logic setup;
  logic addr_hit;
  logic wr_en;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic [31:0] rd_mux;
  logic [8:0] ctrl_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] w1c;
  logic [1:0] events;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  assign setup = I_PSEL & ~I_PENABLE;
  assign addr_hit = (I_PADDR == `FPL_ADDR_CTRL) | (I_PADDR == `FPL_ADDR_STATUS) |
                    (I_PADDR == `FPL_ADDR_IRQ_STAT) | (I_PADDR == `FPL_ADDR_IRQ_MASK) |
                    (I_PADDR == `FPL_ADDR_DIVIDERS);
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & pready_reg & addr_hit;
  assign wr_ctrl = wr_en & (I_PADDR == `FPL_ADDR_CTRL);
  assign wr_stat = wr_en & (I_PADDR == `FPL_ADDR_IRQ_STAT) & I_PSTRB[0];
  assign wr_mask = wr_en & (I_PADDR == `FPL_ADDR_IRQ_MASK) & I_PSTRB[0];
  assign rd_mux = (I_PADDR == `FPL_ADDR_CTRL) ? {23'h000000, ctrl_reg} :
                  (I_PADDR == `FPL_ADDR_STATUS) ? {29'h00000000, out_tri, ref_choice, lol_reg} :
                  (I_PADDR == `FPL_ADDR_IRQ_STAT) ? {30'h00000000, irq_stat_reg} :
                  (I_PADDR == `FPL_ADDR_IRQ_MASK) ? {30'h00000000, mask_reg} :
                  (I_PADDR == `FPL_ADDR_DIVIDERS) ? {2'h0, p_val, 1'h0, rfec_val, 3'h0, fb_div} : 32'h00000000;
  assign ctrl_next[7:0] = (wr_ctrl && I_PSTRB[0]) ? I_PWDATA[7:0] : ctrl_reg[7:0];
  assign ctrl_next[8] = (wr_ctrl && I_PSTRB[1]) ? I_PWDATA[8] : ctrl_reg[8];
  assign mask_next = wr_mask ? I_PWDATA[1:0] : mask_reg;
  assign w1c = wr_stat ? I_PWDATA[1:0] : 2'h0;
  assign events = {~lol_next & lol_reg, lol_next & ~lol_reg};
  // New event wins over a clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~w1c) | events;

  // Output clock level before the output flops
  logic out_level;
  assign out_level = (p_val == `FPL_P_1) ? sync_reg[2] : post_high;

  // Output clock and status flops
  logic clk_p_reg;
  logic clk_n_reg;
  logic oe_reg;
  logic pump_up_reg;
  logic pump_dn_reg;
  logic nbw_reg;
  logic irq_reg;

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      clk_p_reg <= 1'b0;
      clk_n_reg <= 1'b0;
      oe_reg <= 1'b0;
      pump_up_reg <= 1'b0;
      pump_dn_reg <= 1'b0;
      nbw_reg <= 1'b0;
    end else begin
      clk_p_reg <= ~out_tri & out_level;
      clk_n_reg <= ~out_tri & ~out_level;
      oe_reg <= ~out_tri;
      pump_up_reg <= state_next == fec_pll_pkg::LK_WAIT_FB;
      pump_dn_reg <= state_next == fec_pll_pkg::LK_WAIT_REF;
      nbw_reg <= ctrl_reg[`FPL_CTRL_NBW_BIT];
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_reg <= fec_pll_pkg::LK_IDLE;
      diff_reg <= 12'h000;
      lol_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      diff_reg <= diff_next;
      lol_reg <= lol_next;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_reg <= `FPL_CTRL_RESET;
      mask_reg <= `FPL_IRQ_MASK_RESET;
      irq_stat_reg <= 2'h0;
      irq_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_reg & mask_reg);
      pready_reg <= setup;
      pslverr_reg <= setup & ~addr_hit;
      prdata_reg <= (setup && !I_PWRITE) ? rd_mux : 32'h00000000;
    end
  end

  assign O_PRDATA = prdata_reg;
  assign O_PREADY = pready_reg;
  assign O_PSLVERR = pslverr_reg;
  assign O_PUMP_UP = pump_up_reg;
  assign O_PUMP_DN = pump_dn_reg;
  assign O_BW_NARROW = nbw_reg;
  assign O_CLOCK_OUT_POS = clk_p_reg;
  assign O_CLOCK_OUT_NEG = clk_n_reg;
  assign O_CLOCK_OUT_OE = oe_reg;
  assign O_LOCK_LOSS_FLAG = lol_reg;
  assign O_IRQ = irq_reg;

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);

  chk_ref_mux_path: assert property (
    !(ref_choice ? rise[1] : rise[0]) |=> !ref_tick)
    else $error("reference tick from the unselected input");
  chk_ratio_table: assert property (
    (ratio_sel == 2'h1) |-> (mfec_val == rfec_val) && (fb_div == 13'(mfin_val) * 13'(`FPL_MFEC_0X)))
    else $error("repeater ratio not one to one");
  chk_post_decode: assert property (
    (out_sel == 3'h0 || out_sel == 3'h1) |-> p_val == `FPL_P_32)
    else $error("codes 000 and 001 must divide by 32");
  chk_tristate_out: assert property (
    out_tri |=> !O_CLOCK_OUT_OE && !O_CLOCK_OUT_POS && !O_CLOCK_OUT_NEG)
    else $error("output driven in tristate");
  chk_direct_out: assert property (
    (p_val == `FPL_P_1 && !out_tri) |=> O_CLOCK_OUT_POS == $past(sync_reg[2]) && O_CLOCK_OUT_NEG != O_CLOCK_OUT_POS)
    else $error("divide by one output does not follow oscillator");
  chk_lock_set: assert property (
    (miss || (done && meas >= 12'(`FPL_LOL_ASSERT_CYC))) |=> O_LOCK_LOSS_FLAG)
    else $error("lock loss not flagged on large edge error");
  chk_lock_low: assert property (
    (done && !miss && meas < 12'(`FPL_LOL_RELEASE_CYC)) |=> !O_LOCK_LOSS_FLAG)
    else $error("lock loss flag high while locked");
  chk_lock_release: assert property (
    $fell(lol_reg) |-> $past(done) && $past(meas) < 12'(`FPL_LOL_RELEASE_CYC))
    else $error("lock loss released above the lower threshold");
  chk_lock_hold: assert property (
    (!done && !miss) |=> $stable(lol_reg))
    else $error("lock loss flag moved without a comparison");
  chk_nbw_pd: assert property (
    $changed(ctrl_reg[`FPL_CTRL_NBW_BIT]) && $stable(ratio_sel) |=> O_BW_NARROW == $past(ctrl_reg[`FPL_CTRL_NBW_BIT]) && $stable(rfec_val))
    else $error("bandwidth select disturbed the comparison rate");
  chk_irq_sticky: assert property (
    (lol_next && !lol_reg) |=> irq_stat_reg[`FPL_IRQ_LOST_BIT] ##1 (irq_reg || !$past(mask_reg[`FPL_IRQ_LOST_BIT])))
    else $error("lock lost event not latched");

  cov_lock_release: cover property (lol_reg ##1 !lol_reg);
  cov_out_toggle: cover property ($rose(O_CLOCK_OUT_POS) ##[1:40] $fell(O_CLOCK_OUT_POS));
  cov_tristate: cover property (oe_reg ##1 !oe_reg);
  cov_irq: cover property ($rose(irq_reg));
endmodule // fec_pll_ctrl

/* logic/fec_pll_map.svh */
// Register map, field layout, reset values, divider tables and timing counts of the FEC PLL control block
`ifndef FEC_PLL_MAP_SVH
`define FEC_PLL_MAP_SVH

// Register byte addresses
`define FPL_ADDR_CTRL 8'h00
`define FPL_ADDR_STATUS 8'h04
`define FPL_ADDR_IRQ_STAT 8'h08
`define FPL_ADDR_IRQ_MASK 8'h0C
`define FPL_ADDR_DIVIDERS 8'h10

// Control register fields
`define FPL_CTRL_REF_BIT 0
`define FPL_CTRL_RATIO_LSB 1
`define FPL_CTRL_FIN_LO_BIT 3
`define FPL_CTRL_FIN_HI_BIT 4
`define FPL_CTRL_PSEL_LSB 5
`define FPL_CTRL_NBW_BIT 8
`define FPL_CTRL_RESET 9'h040

// Status, interrupt and divider readback fields
`define FPL_STAT_LOL_BIT 0
`define FPL_STAT_REF_BIT 1
`define FPL_STAT_TRI_BIT 2
`define FPL_IRQ_LOST_BIT 0
`define FPL_IRQ_REGAIN_BIT 1
`define FPL_IRQ_MASK_RESET 2'h0
`define FPL_DIV_FB_LSB 0
`define FPL_DIV_RFEC_LSB 16
`define FPL_DIV_P_LSB 24

// Ratio tables, indexed by the ratio select code
`define FPL_MFEC_0X 7'h4F
`define FPL_MFEC_1X 7'h54
`define FPL_RFEC_00 7'h55
`define FPL_RFEC_01 7'h4F
`define FPL_RFEC_10 7'h5A
`define FPL_RFEC_11 7'h54

// Input divider table, indexed by {hi, lo}
`define FPL_MFIN_00 6'h01
`define FPL_MFIN_01 6'h04
`define FPL_MFIN_10 6'h08
`define FPL_MFIN_11 6'h20

// Post divider values and the tristate code
`define FPL_P_1 6'h01
`define FPL_P_4 6'h04
`define FPL_P_8 6'h08
`define FPL_P_32 6'h20
`define FPL_PSEL_TRI 3'h7

// Lock detector timing
`define FPL_CLK_PERIOD_PS 5000
`define FPL_LOL_ASSERT_NS 4
`define FPL_LOL_RELEASE_NS 2
`define FPL_LOL_ASSERT_CYC ((`FPL_LOL_ASSERT_NS * 1000) / `FPL_CLK_PERIOD_PS + 1)
`define FPL_LOL_RELEASE_CYC ((`FPL_LOL_RELEASE_NS * 1000 + `FPL_CLK_PERIOD_PS - 1) / `FPL_CLK_PERIOD_PS)
`define FPL_MISS_LIMIT 12'hFFF

`endif

/* logic/fec_pll_pkg.sv */
// Types shared by the FEC PLL control block
package fec_pll_pkg;
  typedef enum logic [1:0] {
    LK_IDLE = 2'h0,
    LK_WAIT_FB = 2'h1,
    LK_WAIT_REF = 2'h3
  } lock_state_type;
endpackage

/* logic/pulse_divider.sv */
// Edge-counting divider: one tick per i_div source edges and a half-period level
`timescale 1ns/1ps
module pulse_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Source edge and divide value
  input wire logic i_edge,
  input wire logic [W-1:0] i_div,
  // Divided outputs
  output logic o_tick,
  output logic o_high
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic tick_reg;
  logic high_reg;
  logic wrap;

  assign wrap = count_reg >= (i_div - W'(1));
  assign count_next = !i_edge ? count_reg : (wrap ? '0 : count_reg + W'(1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
      high_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= i_edge & wrap;
      high_reg <= count_next < (i_div >> 1);
    end
  end

  assign o_tick = tick_reg;
  assign o_high = high_reg;

  chk_tick_cause: assert property (
    @(posedge i_clk) disable iff (i_rst) tick_reg |-> $past(i_edge) && $past(count_reg) >= $past(i_div) - W'(1))
    else $error("divider tick without a terminal source edge");
endmodule // pulse_divider

/* test/fec_pll_source.sv */
// Reference clock sources and oscillator stand-in facing the FEC PLL control block
`timescale 1ns/1ps
module fec_pll_source (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Run and reference skew
  input wire logic i_run,
  input wire logic i_skew,
  // Source pins
  output logic o_ref_a,
  output logic o_ref_b,
  output logic o_osc
);
  logic [2:0] phase_reg;
  logic [1:0] hist_reg;
  logic skew_reg;
  logic [3:0] b_reg;
  // Jitter-free edges, free of the output clock; all stand still while not running
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= 3'h0;
      hist_reg <= 2'h0;
      skew_reg <= 1'b0;
      b_reg <= 4'h0;
    end else if (i_run) begin
      phase_reg <= phase_reg + 3'h1;
      hist_reg <= {hist_reg[0], phase_reg < 3'h4};
      // Skew taken only while the oscillator is low, so no edge is doubled
      if (phase_reg == 3'h6) begin
        skew_reg <= i_skew;
      end
      b_reg <= (b_reg == 4'h9) ? 4'h0 : b_reg + 4'h1;
    end
  end
  assign o_osc = hist_reg[0];
  assign o_ref_a = hist_reg[skew_reg];
  assign o_ref_b = b_reg < 4'h5;
endmodule // fec_pll_source

/* test/fec_pll_ctrl_bench.sv */
// Self-checking bench of the FEC PLL control block
`timescale 1ns/1ps
module fec_pll_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, up, dn, bw, pos, neg, oe, flag, irq, ref_a, ref_b, osc, err, narrow_bandwidth_select;
  logic run = 1'b0;
  logic skew = 1'b0;
  logic prev_pos = 1'b0;
  logic prev_osc = 1'b0;
  logic [31:0] rd;
  integer fails = 0;
  integer tests_run = 0;
  integer pos_n = 0;
  integer osc_n = 0;
  integer neg_bad = 0;
  integer up_n = 0;
  integer dn_n = 0;
  logic [3:0] pstrb = 4'hF;
  integer seed = 32'hBE2BA9CF;
  int rfec_t[4] = '{85, 79, 90, 84};
  int mfin_t[4] = '{1, 4, 8, 32};
  int p_t[8] = '{32, 32, 1, 4, 8, 4, 8, 32};
  int p;

  fec_pll_ctrl fec_pll_ctrl_i (.I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_REF_IN_A(ref_a), .I_REF_IN_B(ref_b), .I_OSC_IN(osc),
    .O_PUMP_UP(up), .O_PUMP_DN(dn), .O_BW_NARROW(bw), .O_CLOCK_OUT_POS(pos), .O_CLOCK_OUT_NEG(neg),
    .O_CLOCK_OUT_OE(oe), .O_LOCK_LOSS_FLAG(flag), .O_IRQ(irq));
  fec_pll_source fec_pll_source_i (.i_clk(clk), .i_rst(rst), .i_run(run), .i_skew(skew),
    .o_ref_a(ref_a), .o_ref_b(ref_b), .o_osc(osc));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Edge counts of the output clock and oscillator
  always @(posedge clk) begin
    prev_pos <= pos;
    prev_osc <= osc;
    if (pos === 1'b1 && prev_pos === 1'b0) pos_n = pos_n + 1;
    if (osc === 1'b1 && prev_osc === 1'b0) osc_n = osc_n + 1;
    if (oe === 1'b1 && neg !== ~pos) neg_bad = neg_bad + 1;
    if (up === 1'b1) up_n = up_n + 1;
    if (dn === 1'b1) dn_n = dn_n + 1;
  end

  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_pin(input string what, input logic exp, input logic seen);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    integer n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk_pin("pready", 1'b1, pready);
  endtask

  task automatic wait_flag(input logic v, input integer lim);
    integer n;
    n = 0;
    while (flag !== v && n < lim) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
  endtask

  // Output clock rate against oscillator rate for one select code
  task automatic out_rate(input logic [2:0] ps);
    apb(1'b1, 8'h00, {24'h0, ps, 5'h02});
    cyc(40);
    pos_n = 0;
    osc_n = 0;
    cyc(2048);
    p = p_t[ps];
    chk_pin("clock_out_rate", 1'b1, (pos_n * p - osc_n <= p) && (osc_n - pos_n * p <= p));
  endtask

  initial begin
    #400000;
    fails = fails + 1;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk_reg("ctrl", 32'h00000040, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk_reg("irq_mask", 32'h0, rd);
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    apb(1'b0, 8'h04, 32'h0);
    chk_reg("status", 32'h00000001, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk_pin("slverr", 1'b1, err);
    chk_reg("unmapped", 32'h0, rd);
    for (int c = 0; c < 128; c++) begin
      narrow_bandwidth_select = 1'($random(seed));
      apb(1'b1, 8'h00, {23'h0, narrow_bandwidth_select, c[6:0], 1'b0});
      cyc(2);
      apb(1'b0, 8'h10, 32'h0);
      p = p_t[c[6:4]];
      chk_reg("dividers", mfin_t[c[3:2]] * (c[1] ? 84 : 79) + (rfec_t[c[1:0]] << 16) + (p << 24), rd);
      chk_pin("bw_narrow", narrow_bandwidth_select, bw);
      chk_pin("output_enable", c[6:4] != 3'h7, oe);
      chk_pin("output_tri", 1'b0, (c[6:4] == 3'h7) && (pos !== 1'b0 || neg !== 1'b0));
    end
    // Byte lane 1 off: bit 8 keeps its value
    pstrb <= 4'h1;
    apb(1'b1, 8'h00, 32'h00000100);
    pstrb <= 4'hF;
    apb(1'b0, 8'h00, 32'h0);
    chk_reg("ctrl_strobe", {23'h0, narrow_bandwidth_select, 8'h00}, rd);
    // Matched dividers, reference A copies the oscillator
    apb(1'b1, 8'h00, 32'h00000062);
    apb(1'b1, 8'h0C, 32'h00000003);
    apb(1'b1, 8'h08, 32'h00000003);
    run <= 1'b1;
    wait_flag(1'b0, 3000);
    chk_pin("lock_loss_flag", 1'b0, flag);
    cyc(3);
    apb(1'b0, 8'h08, 32'h0);
    chk_reg("irq_stat", 32'h00000002, rd);
    chk_pin("irq", 1'b1, irq);
    apb(1'b1, 8'h08, 32'h00000002);
    cyc(3);
    chk_pin("irq_cleared", 1'b0, irq);
    up_n = 0;
    dn_n = 0;
    for (int s = 0; s < 7; s++) begin
      out_rate(s[2:0]);
    end
    chk_pin("clock_out_complement", 1'b0, neg_bad != 0);
    chk_pin("still_locked", 1'b0, flag);
    chk_pin("pump_idle", 1'b0, up_n != 0 || dn_n != 0);
    up_n = 0;
    dn_n = 0;
    // One cycle of skew is beyond the assert threshold
    apb(1'b1, 8'h0C, 32'h00000001);
    skew <= 1'b1;
    wait_flag(1'b1, 3000);
    chk_pin("lock_loss_flag", 1'b1, flag);
    cyc(3);
    chk_pin("irq_lost", 1'b1, irq);
    chk_pin("pump_dn_only", 1'b1, dn_n != 0 && up_n == 0);
    apb(1'b0, 8'h04, 32'h0);
    chk_reg("status", 32'h00000001, rd);
    apb(1'b1, 8'h0C, 32'h0);
    cyc(3);
    chk_pin("irq_masked", 1'b0, irq);
    skew <= 1'b0;
    wait_flag(1'b0, 3000);
    chk_pin("lock_loss_flag", 1'b0, flag);
    // Reference B runs at another rate
    apb(1'b1, 8'h00, 32'h00000063);
    wait_flag(1'b1, 3000);
    chk_pin("lock_loss_flag", 1'b1, flag);
    apb(1'b0, 8'h04, 32'h0);
    chk_reg("status", 32'h00000003, rd);
    report_and_stop();
  end
endmodule // fec_pll_ctrl_bench
